// ===== core/frrp_pkg.sv
// frrp_pkg: shared constants and types for the fault restart retry policy
// assumes: one 50 MHz clock; settings held stable by the configuration logic
package frrp_pkg;

  // ----------------------------------------------------------------------
  // retry field codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] RETRY_TWICE = 3'h2;
  localparam logic [2:0] RETRY_THREE = 3'h3;
  localparam logic [2:0] RETRY_FOUR = 3'h4;
  localparam logic [2:0] RETRY_FIVE = 3'h5;
  localparam logic [2:0] RETRY_SIX = 3'h6;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int UNIT_US = 1;
  // cycles per delay unit tick
  localparam int UNIT_CYC = (CLK_HZ / 1000000) * UNIT_US;
  localparam int UNIT_W = 16;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] retryCode;
    logic [2:0] delayField;
    logic [7:0] unitScale;
  } frrp_cfg_t;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_WAIT = 4'h2,
    ST_TRY = 4'h4,
    ST_LATCHOFF = 4'h8
  } frrp_state_t;

endpackage : frrp_pkg

// ===== core/frrp_retry.sv
// frrp_retry: restart retry policy after an output fault
// assumes: fault, restartOk, offCmd inputs synchronous to clock
// Summary of operation
// R1 - codes 100, 101, 110 give exactly four, five, six restart attempts
// R2 - when all permitted attempts fail the output is disabled
// R3 - output stays off after exhaustion until the fault is cleared
// R4 - attempt starts spaced by delay field times the fault delay unit; the code waits that product plus one unit
// R5 - code 111 retries forever until off command, bias loss or other fault
// R6 - codes 010 and 011 give two and three attempts, same latch-off
`timescale 1ns/10ps
module frrp_retry #(
  parameter int UNIT_CYC = frrp_pkg::UNIT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // settings
  input wire frrp_pkg::frrp_cfg_t cfg,
  // converter events
  input wire logic fault,
  input wire logic restartOk,
  input wire logic faultClear,
  input wire logic offCmd,
  input wire logic biasLost,
  input wire logic otherFault,
  // outputs
  output logic outputEnable,
  output logic restartPulse,
  output logic latchedOff,
  output logic [2:0] attemptsDone
);

  function automatic logic [2:0] limitOf(input logic [2:0] code);
    unique case (code)
      frrp_pkg::RETRY_TWICE: limitOf = 3'h2;
      frrp_pkg::RETRY_THREE: limitOf = 3'h3;
      frrp_pkg::RETRY_FOUR: limitOf = 3'h4;
      frrp_pkg::RETRY_FIVE: limitOf = 3'h5;
      frrp_pkg::RETRY_SIX: limitOf = 3'h6;
      default: limitOf = 3'h0;
    endcase
  endfunction : limitOf

  typedef struct packed {
    frrp_pkg::frrp_state_t st;
    logic [2:0] tries;
    logic [10:0] units;
    logic pulse;
  } frrp_st_t;

  frrp_st_t s_q, s_d;
  logic tick;
  logic stopAll;
  logic [10:0] spacing;

  // ----------------------------------------------------------------------
  // delay unit divider
  // ----------------------------------------------------------------------
  frrp_tick #(.UNIT_CYC(UNIT_CYC)) uTick (
    .clock(clock),
    .arst_n(arst_n),
    .run(s_q.st == frrp_pkg::ST_WAIT),
    .tick(tick)
  );

  // zero spacing still waits one unit so attempts never fire back to back
  assign spacing = 11'(cfg.delayField) * 11'(cfg.unitScale);
  assign stopAll = offCmd | biasLost | otherFault; // R5

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    unique case (s_q.st)
      frrp_pkg::ST_RUN: begin
        if (fault) begin
          s_d.st = frrp_pkg::ST_WAIT;
          s_d.tries = '0;
          s_d.units = '0;
        end
      end
      frrp_pkg::ST_WAIT: begin
        if (stopAll && cfg.retryCode == frrp_pkg::RETRY_FOREVER) begin
          s_d.st = frrp_pkg::ST_LATCHOFF; // R5
        end else if (tick) begin
          if (s_q.units >= spacing) begin // R4
            s_d.st = frrp_pkg::ST_TRY;
            s_d.pulse = 1'b1;
            s_d.units = '0;
            if (cfg.retryCode != frrp_pkg::RETRY_FOREVER) begin
              s_d.tries = s_q.tries + 1'b1; // R1 R6
            end
          end else begin
            s_d.units = s_q.units + 1'b1;
          end
        end
      end
      frrp_pkg::ST_TRY: begin
        if (restartOk) begin
          s_d.st = frrp_pkg::ST_RUN;
        end else if (fault) begin
          if (cfg.retryCode != frrp_pkg::RETRY_FOREVER &&
              s_q.tries >= limitOf(cfg.retryCode)) begin
            s_d.st = frrp_pkg::ST_LATCHOFF; // R2 R1 R6
          end else if (stopAll &&
                       cfg.retryCode == frrp_pkg::RETRY_FOREVER) begin
            s_d.st = frrp_pkg::ST_LATCHOFF; // R5
          end else begin
            s_d.st = frrp_pkg::ST_WAIT;
          end
        end
      end
      frrp_pkg::ST_LATCHOFF: begin
        if (faultClear) begin
          s_d.st = frrp_pkg::ST_RUN; // R3
          s_d.tries = '0;
        end
      end
      default: s_d.st = frrp_pkg::ST_LATCHOFF;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: frrp_pkg::ST_RUN, tries: 3'h0, units: 11'h0, pulse: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign outputEnable = (s_q.st == frrp_pkg::ST_RUN) ||
                        (s_q.st == frrp_pkg::ST_TRY); // R2
  assign latchedOff = (s_q.st == frrp_pkg::ST_LATCHOFF);
  assign restartPulse = s_q.pulse;
  assign attemptsDone = s_q.tries;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence sExhaust;
    s_q.st == frrp_pkg::ST_TRY && fault && !restartOk &&
    cfg.retryCode != frrp_pkg::RETRY_FOREVER &&
    s_q.tries >= limitOf(cfg.retryCode);
  endsequence

  a_latch_on_exhaust: assert property ( // R2
    @(posedge clock) disable iff (!arst_n)
    sExhaust |=> latchedOff && !outputEnable)
    else $error("no latch-off after last attempt");

  a_stays_off: assert property ( // R3
    @(posedge clock) disable iff (!arst_n)
    latchedOff && !faultClear |=> latchedOff)
    else $error("latch-off left without fault clear");

  a_count_limit: assert property ( // R1
    @(posedge clock) disable iff (!arst_n)
    cfg.retryCode != frrp_pkg::RETRY_FOREVER && limitOf(cfg.retryCode) != 0
    |-> attemptsDone <= limitOf(cfg.retryCode))
    else $error("attempt count over limit");

  a_small_codes: assert property ( // R6
    @(posedge clock) disable iff (!arst_n)
    restartPulse && cfg.retryCode == frrp_pkg::RETRY_TWICE
    |-> attemptsDone <= 3'h2)
    else $error("code 010 exceeded two attempts");

  a_spacing_held: assert property ( // R4
    @(posedge clock) disable iff (!arst_n)
    restartPulse |=> !restartPulse [*2])
    else $error("restart attempts too close");

  a_forever_stop: assert property ( // R5
    @(posedge clock) disable iff (!arst_n)
    s_q.st == frrp_pkg::ST_WAIT && stopAll &&
    cfg.retryCode == frrp_pkg::RETRY_FOREVER |=> latchedOff)
    else $error("endless retry not stopped");

  a_forever_nocount: assert property ( // R5
    @(posedge clock) disable iff (!arst_n)
    cfg.retryCode == frrp_pkg::RETRY_FOREVER && restartPulse
    |-> $stable(attemptsDone))
    else $error("endless retry counted attempts");

  a_pulse_enables: assert property ( // R4
    @(posedge clock) disable iff (!arst_n)
    restartPulse |-> outputEnable)
    else $error("restart pulse with output off");

  sequence sEndlessFail;
    s_q.st == frrp_pkg::ST_TRY && fault && !restartOk &&
    cfg.retryCode == frrp_pkg::RETRY_FOREVER;
  endsequence

  a_endless_rewait: assert property ( // R5
    @(posedge clock) disable iff (!arst_n)
    sEndlessFail ##0 !stopAll |=> s_q.st == frrp_pkg::ST_WAIT)
    else $error("endless retry gave up early");

  a_endless_halt: assert property ( // R5
    @(posedge clock) disable iff (!arst_n)
    sEndlessFail ##0 stopAll |=> latchedOff && !outputEnable)
    else $error("endless retry ignored a stop");

  a_clear_restores: assert property ( // R3
    @(posedge clock) disable iff (!arst_n)
    latchedOff && faultClear |=> outputEnable && attemptsDone == 3'h0)
    else $error("fault clear did not restore output");

  a_early_attempt: assert property ( // R4
    @(posedge clock) disable iff (!arst_n)
    s_q.st == frrp_pkg::ST_WAIT && tick && s_q.units < spacing
    |=> !restartPulse)
    else $error("attempt started before its spacing");

  a_fault_drops: assert property ( // R1
    @(posedge clock) disable iff (!arst_n)
    s_q.st == frrp_pkg::ST_RUN && fault
    |=> !outputEnable && attemptsDone == 3'h0)
    else $error("fault did not start a fresh retry run");

endmodule : frrp_retry

// ===== core/frrp_tick.sv
// frrp_tick: delay unit tick divider, one-cycle enable per unit
// assumes: single clock domain, asynchronous active-low reset
`timescale 1ns/10ps
module frrp_tick #(
  parameter int UNIT_CYC = frrp_pkg::UNIT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // control
  input wire logic run,
  output logic tick
);

  typedef struct packed {
    logic [frrp_pkg::UNIT_W-1:0] cnt;
    logic tick;
  } frrp_tick_st_t;

  frrp_tick_st_t s_q, s_d;

  // last count of a unit, cut to the counter width on purpose
  localparam int UnitLast = UNIT_CYC - 1;
  localparam logic [frrp_pkg::UNIT_W-1:0] CNT_LAST =
    UnitLast[frrp_pkg::UNIT_W-1:0];

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == CNT_LAST) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : frrp_tick

// ===== dv/frrp_conv_model.sv
// frrp_conv_model: converter stand-in whose restarts fail nFail times
// assumes: answers each restart pulse before the next rising edge
`timescale 1ns/10ps
module frrp_conv_model (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // bench control
  input wire logic active,
  input wire logic [7:0] nFail,
  input wire logic restartPulse,
  // converter status
  output logic fault,
  output logic restartOk
);
  logic [7:0] tries;
  // falling edge, so the try state sees the answer at the next rise
  always @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fault <= 1'b0;
      restartOk <= 1'b0;
      tries <= 8'h00;
    end else if (!active) begin
      fault <= 1'b0;
      restartOk <= 1'b0;
      tries <= 8'h00;
    end else if (!restartOk) begin
      fault <= 1'b1;
      if (restartPulse) begin
        tries <= tries + 8'h01;
        if (tries >= nFail) begin
          fault <= 1'b0;
          restartOk <= 1'b1;
        end
      end
    end
  end
endmodule : frrp_conv_model

// ===== dv/frrp_retry_tb_top.sv
// frrp_retry_tb_top: self-checking bench for the retry policy
// assumes: design built with UNIT_CYC of 2; inputs move at falling edge
`timescale 1ns/10ps
module frrp_retry_tb_top;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  frrp_pkg::frrp_cfg_t cfg = '0;
  logic faultClear = 1'b0;
  logic offCmd = 1'b0;
  logic biasLost = 1'b0;
  logic otherFault = 1'b0;
  logic active = 1'b0;
  logic [7:0] nFail = 8'h00;
  logic fault, restartOk, outputEnable, restartPulse, latchedOff;
  logic [2:0] attemptsDone;
  int miscompares = 0;
  int n_tests = 0;
  int np, g1;
  // divider shortened so long spacings stay cheap to run
  localparam int UnitCycSim = 2;
  always #10 clock = ~clock;
  frrp_retry #(.UNIT_CYC(UnitCycSim)) u_frrp_retry (.clock(clock),
    .arst_n(arst_n),
    .cfg(cfg), .fault(fault), .restartOk(restartOk),
    .faultClear(faultClear), .offCmd(offCmd), .biasLost(biasLost),
    .otherFault(otherFault), .outputEnable(outputEnable),
    .restartPulse(restartPulse), .latchedOff(latchedOff),
    .attemptsDone(attemptsDone));
  frrp_conv_model u_frrp_conv_model (.clock(clock), .arst_n(arst_n),
    .active(active), .nFail(nFail), .restartPulse(restartPulse),
    .fault(fault), .restartOk(restartOk));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // one fault episode: count attempts and the gap between the first two
  task automatic episode(input logic [2:0] code, input logic [2:0] df,
      input logic [7:0] us, input logic [7:0] nf);
    int t1;
    t1 = 0;
    cfg = '{code, df, us};
    nFail = nf;
    active = 1'b1;
    np = 0;
    g1 = 0;
    for (int i = 0; i < 400; i++) begin
      @(negedge clock);
      if (restartPulse === 1'b1) begin
        np++;
        if (np == 1) t1 = i;
        if (np == 2) g1 = i - t1;
      end
    end
  endtask : episode
  task automatic clear_all;
    active = 1'b0;
    offCmd = 1'b0;
    biasLost = 1'b0;
    otherFault = 1'b0;
    @(negedge clock);
    faultClear = 1'b1;
    @(negedge clock);
    faultClear = 1'b0;
    repeat (4) @(negedge clock);
    check(16'(latchedOff), 16'h0000);
    check(16'(outputEnable), 16'h0001);
  endtask : clear_all
  task automatic test_counted_codes;
    logic [15:0] expN;
    for (int c = 0; c <= 6; c++) begin
      // codes below 010 allow a single attempt before latch-off
      expN = (c < 2) ? 16'h0001 : 16'(c);
      episode(3'(c), 3'h0, 8'h01, 8'hff);
      check(16'(np), expN);
      check(16'(attemptsDone), expN);
      check(16'(outputEnable), 16'h0000);
      check(16'(latchedOff), 16'h0001);
      clear_all;
    end
    $display("test counted codes done");
  endtask : test_counted_codes
  task automatic test_spacing;
    int gapShort;
    int gapLong;
    episode(3'h4, 3'h1, 8'h02, 8'hff);
    gapShort = g1;
    clear_all;
    episode(3'h4, 3'h3, 8'h02, 8'hff);
    gapLong = g1;
    // four more delay units between attempt starts
    check(16'(gapLong - gapShort), 16'(4 * UnitCycSim));
    check(16'(np), 16'h0004);
    clear_all;
    // same product of field and unit scale gives the same spacing
    episode(3'h4, 3'h1, 8'h06, 8'hff);
    check(16'(g1), 16'(gapLong));
    clear_all;
    $display("test spacing done");
  endtask : test_spacing
  task automatic test_recovery;
    episode(3'h4, 3'h0, 8'h01, 8'h01);
    check(16'(np), 16'h0002);
    check(16'(outputEnable), 16'h0001);
    check(16'(latchedOff), 16'h0000);
    check(16'(attemptsDone), 16'h0002);
    clear_all;
    $display("test recovery done");
  endtask : test_recovery
  task automatic test_endless;
    for (int s = 0; s < 3; s++) begin
      episode(3'h7, 3'h0, 8'h00, 8'hff);
      check(16'(np > 8), 16'h0001);
      check(16'(latchedOff), 16'h0000);
      check(16'(attemptsDone), 16'h0000);
      offCmd = (s == 0);
      biasLost = (s == 1);
      otherFault = (s == 2);
      repeat (20) @(negedge clock);
      check(16'(latchedOff), 16'h0001);
      clear_all;
    end
    $display("test endless retry done");
  endtask : test_endless
  initial begin
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    test_counted_codes;
    test_spacing;
    test_recovery;
    test_endless;
    summarize;
  end
  // whole run needs about 6000 cycles
  initial begin
    #400000;
    miscompares++;
    summarize;
  end
endmodule : frrp_retry_tb_top
